// [mesf_params.svh]
// Constants for the second event status word of the metering core.
// Assumes inclusion by the block's files other than the synchroniser and the package; definitions only.
`ifndef MESF_PARAMS_SVH
`define MESF_PARAMS_SVH

// Register indices (printed offsets)
`define MESF_ADDR_STATUS     16'he503
`define MESF_ADDR_MASK       16'he50b
`define MESF_ADDR_NOLOAD     16'he600
`define MESF_ADDR_PHSTAT     16'he601
`define MESF_ADDR_CONFIG     16'he618
`define MESF_ADDR_LEVEL      16'he620

// Status word field positions
`define MESF_B_TOTAL_NOLOAD_FLAG         0
`define MESF_B_FUNDAMENTAL_NOLOAD_FLAG        1
`define MESF_B_APPARENT_NOLOAD_FLAG       2
`define MESF_B_ZXTO_LO       3
`define MESF_B_ZX_LO         9
`define MESF_B_RESET_COMPLETE_FLAG       15
`define MESF_B_SAG           16
`define MESF_B_OI            17
`define MESF_B_OV            18
`define MESF_B_SEQ           19
`define MESF_B_MISM          20
`define MESF_B_RSVD1         21
`define MESF_B_PKI           23
`define MESF_B_PKV           24
`define MESF_B_CRC           25

// Flag bits that hardware may set, and fixed read values
`define MESF_FLAG_MASK       32'h03bfffff
`define MESF_FIXED_ONES      32'h00200000
`define MESF_STATUS_RST      32'h00208000

// Phase register field positions
`define MESF_NL_TOT_LO       0
`define MESF_NL_FUN_LO       3
`define MESF_NL_APP_LO       6
`define MESF_PS_OI_LO        3
`define MESF_PS_OV_LO        9
`define MESF_PS_SAG_LO       12

// Configuration bits
`define MESF_CFG_SOFTWARE_RESET_REQUEST       7
`define MESF_CFG_RUN         0

// Reset sequencing length in clocks
`define MESF_RST_CYCLES      8'h10

`endif

// [mesf_pkg.sv]
// Types shared by the status block files.
// Assumes nothing beyond a SystemVerilog compiler.
package mesf_pkg;
    typedef enum logic [2:0] {
        MESF_SEQ_IDLE  = 3'b001,
        MESF_SEQ_ARMED = 3'b010,
        MESF_SEQ_HOLD  = 3'b100
    } mesf_seq_t;
endpackage

// [mesf_sync.sv]
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes input is asynchronous to ref_clk.
`timescale 1ns/1ps
module mesf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] lvl_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    wire  [W-1:0] agree_w = ~(s2_q ^ s3_q);

    // Only stage two reads stage one; level moves when two and three agree
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (agree_w & s2_q) | (~agree_w & lvl_q);
        end
    end

    assign lvl_out = lvl_q;
endmodule

// [mesf_seq_chk.sv]
// Phase rotation checker: A rising, then C rising before B, is an error.
// Assumes crossing inputs are single-cycle pulses on ref_clk.
`timescale 1ns/1ps
`include "mesf_params.svh"
module mesf_seq_chk (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Rising crossings of the three voltages
    input  wire logic rise_a,
    input  wire logic rise_b,
    input  wire logic rise_c,
    // Result
    output logic      seq_err
);
    mesf_pkg::mesf_seq_t st_q;
    mesf_pkg::mesf_seq_t st_d;
    logic                err_q;
    wire                 bad_w = (st_q == mesf_pkg::MESF_SEQ_ARMED)
                                 && rise_c && !rise_b;

    // After A, the next of B or C decides the order
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            mesf_pkg::MESF_SEQ_IDLE: begin
                if (rise_a) st_d = mesf_pkg::MESF_SEQ_ARMED;
            end
            mesf_pkg::MESF_SEQ_ARMED: begin
                if (rise_b || rise_c) st_d = mesf_pkg::MESF_SEQ_HOLD;
            end
            mesf_pkg::MESF_SEQ_HOLD: begin
                st_d = rise_a ? mesf_pkg::MESF_SEQ_ARMED
                              : mesf_pkg::MESF_SEQ_IDLE;
            end
            default: st_d = mesf_pkg::MESF_SEQ_IDLE;
        endcase
    end

    // Error is a one-cycle pulse
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q  <= mesf_pkg::MESF_SEQ_IDLE;
            err_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            err_q <= bad_w;
        end
    end

    assign seq_err = err_q;
endmodule

// [mesf_status.sv]
// Second event status word, phase registers, mask and reset sequencing.
// Assumes event inputs are one-cycle pulses from the DSP on ref_clk,
// except the wake pin power_mode_wake, which is an asynchronous level.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "mesf_params.svh"
module mesf_status #(
    parameter int LVL_W = 24
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Register port
    input  wire logic [15:0]      reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    // No-load entry, one bit per phase
    input  wire logic [2:0]       total_noload_phases,
    input  wire logic [2:0]       fundamental_noload_phases,
    input  wire logic [2:0]       apparent_noload_phases,
    // Zero crossings, voltage A..C then current A..C
    input  wire logic [5:0]       crossing_timeout,
    input  wire logic [5:0]       crossing_seen,
    input  wire logic [2:0]       voltage_rise,
    // Level events, one bit per phase
    input  wire logic [2:0]       dip_phase_bits,
    input  wire logic [2:0]       overcurrent_phase_bits,
    input  wire logic [2:0]       overvoltage_phase_bits,
    // Neutral comparison
    input  wire logic [LVL_W-1:0] summed_phase_current,
    input  wire logic [LVL_W-1:0] neutral_current_sample,
    // Peak periods and checksum
    input  wire logic             current_peak_done,
    input  wire logic             voltage_peak_done,
    input  wire logic [31:0]      config_checksum,
    // Reset sources
    input  wire logic             power_mode_wake,
    // Outputs
    output logic                  interrupt_out_one_n,
    output logic                  core_reset_pulse
);
    logic [31:0]      status_q;
    logic [31:0]      mask_q;
    logic [8:0]       noload_q;
    logic [14:0]      phstat_q;
    logic [LVL_W-1:0] level_q;
    logic [31:0]      crc_ref_q;
    logic             run_q;
    logic [7:0]       rst_cnt_q;
    logic             rst_busy_q;
    logic [31:0]      rdata_q;
    logic             irq_n_q;
    logic             seq_err;
    logic             wake_lvl;

    // The wake pin comes from the power-mode controller in another domain
    mesf_sync #(
        .W (1)
    ) u_wake (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pin_in  (power_mode_wake),
        .lvl_out (wake_lvl)
    );

    mesf_seq_chk u_seq (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .rise_a  (voltage_rise[0]),
        .rise_b  (voltage_rise[1]),
        .rise_c  (voltage_rise[2]),
        .seq_err (seq_err)
    );

    // Address decode
    wire sel_stat  = reg_addr == `MESF_ADDR_STATUS;
    wire sel_mask  = reg_addr == `MESF_ADDR_MASK;
    wire sel_nl    = reg_addr == `MESF_ADDR_NOLOAD;
    wire sel_ps    = reg_addr == `MESF_ADDR_PHSTAT;
    wire sel_cfg   = reg_addr == `MESF_ADDR_CONFIG;
    wire sel_lvl   = reg_addr == `MESF_ADDR_LEVEL;
    wire wr_stat   = reg_wr && sel_stat;
    wire wr_cfg    = reg_wr && sel_cfg;

    // Wake edge: return to normal mode restarts the reset sequence
    logic wake_prev_q;
    wire  wake_rise = wake_lvl && !wake_prev_q;
    wire  software_reset_request_w   = wr_cfg && reg_wdata[`MESF_CFG_SOFTWARE_RESET_REQUEST];
    wire  start_rst = software_reset_request_w || wake_rise;
    wire  rst_end   = rst_busy_q && (rst_cnt_q == 8'h01);

    // Neutral mismatch: |sum| - |neutral| in magnitude above the level
    wire [LVL_W-1:0] abs_sum = summed_phase_current[LVL_W-1]
                             ? -summed_phase_current : summed_phase_current;
    wire [LVL_W-1:0] abs_neu = neutral_current_sample[LVL_W-1]
                             ? -neutral_current_sample
                             : neutral_current_sample;
    wire [LVL_W-1:0] diff_w  = (abs_sum >= abs_neu) ? abs_sum - abs_neu
                                                    : abs_neu - abs_sum;
    wire mismatch_w = diff_w > level_q;

    // Checksum differs from the one captured when run went high
    wire crc_bad_w = run_q && (config_checksum != crc_ref_q);

    // Event vector in status-word layout
    logic [31:0] ev_w;
    always_comb begin
        ev_w = 32'h00000000;
        ev_w[`MESF_B_TOTAL_NOLOAD_FLAG]   = |total_noload_phases;
        ev_w[`MESF_B_FUNDAMENTAL_NOLOAD_FLAG]  = |fundamental_noload_phases;
        ev_w[`MESF_B_APPARENT_NOLOAD_FLAG] = |apparent_noload_phases;
        ev_w[`MESF_B_ZXTO_LO +: 6] = crossing_timeout;
        ev_w[`MESF_B_ZX_LO +: 6]   = crossing_seen;
        ev_w[`MESF_B_RESET_COMPLETE_FLAG] = rst_end;
        ev_w[`MESF_B_SAG]     = |dip_phase_bits;
        ev_w[`MESF_B_OI]      = |overcurrent_phase_bits;
        ev_w[`MESF_B_OV]      = |overvoltage_phase_bits;
        ev_w[`MESF_B_SEQ]     = seq_err;
        ev_w[`MESF_B_MISM]    = mismatch_w;
        ev_w[`MESF_B_PKI]     = current_peak_done;
        ev_w[`MESF_B_PKV]     = voltage_peak_done;
        ev_w[`MESF_B_CRC]     = crc_bad_w;
    end

    // Set beats write-one-clear; fixed bits forced afterwards
    wire [31:0] clr_w    = wr_stat ? reg_wdata : 32'h00000000;
    wire [31:0] stat_d   = ((status_q & ~clr_w) | ev_w)
                           & `MESF_FLAG_MASK;
    wire [31:0] stat_fix = stat_d | `MESF_FIXED_ONES;

    // Interrupt: masked flags plus the unmaskable reset-complete flag
    wire [31:0] irq_src  = stat_fix & mask_q & ~`MESF_FIXED_ONES;
    wire        irq_d    = |irq_src || stat_fix[`MESF_B_RESET_COMPLETE_FLAG];

    // Read mux, unmapped addresses read zero
    wire [31:0] rd_mux =
        sel_stat ? status_q :
        sel_mask ? mask_q :
        sel_nl   ? {23'h000000, noload_q} :
        sel_ps   ? {17'h00000, phstat_q} :
        sel_cfg  ? {31'h00000000, run_q} :
        sel_lvl  ? {{(32-LVL_W){1'b0}}, level_q} : 32'h00000000;

    // Phase register next values: last reported phase group stays
    wire [8:0] nl_d = {
        |apparent_noload_phases    ? apparent_noload_phases
                                   : noload_q[`MESF_NL_APP_LO +: 3],
        |fundamental_noload_phases ? fundamental_noload_phases
                                   : noload_q[`MESF_NL_FUN_LO +: 3],
        |total_noload_phases       ? total_noload_phases
                                   : noload_q[`MESF_NL_TOT_LO +: 3]};
    wire [14:0] ps_d = {
        |dip_phase_bits ? dip_phase_bits : phstat_q[`MESF_PS_SAG_LO +: 3],
        |overvoltage_phase_bits ? overvoltage_phase_bits
                                : phstat_q[`MESF_PS_OV_LO +: 3],
        phstat_q[8:6],
        |overcurrent_phase_bits ? overcurrent_phase_bits
                                : phstat_q[`MESF_PS_OI_LO +: 3],
        phstat_q[2:0]};

    // Status word and phase registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= `MESF_STATUS_RST;
            noload_q <= 9'h000;
            phstat_q <= 15'h0000;
        end else if (rst_busy_q) begin
            status_q <= (`MESF_STATUS_RST & ~(32'h1 << `MESF_B_RESET_COMPLETE_FLAG))
                        | ev_w;
            noload_q <= 9'h000;
            phstat_q <= 15'h0000;
        end else begin
            status_q <= stat_fix;
            noload_q <= nl_d;
            phstat_q <= ps_d;
        end
    end

    // Mask, level, run and checksum capture; soft reset returns defaults
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q    <= 32'h00000000;
            level_q   <= '0;
            run_q     <= 1'b0;
            crc_ref_q <= 32'h00000000;
        end else if (rst_busy_q) begin
            mask_q    <= 32'h00000000;
            level_q   <= '0;
            run_q     <= 1'b0;
            crc_ref_q <= 32'h00000000;
        end else begin
            if (reg_wr && sel_mask) mask_q <= reg_wdata;
            if (reg_wr && sel_lvl) level_q <= reg_wdata[LVL_W-1:0];
            if (wr_cfg) run_q <= reg_wdata[`MESF_CFG_RUN];
            if (wr_cfg && reg_wdata[`MESF_CFG_RUN] && !run_q)
                crc_ref_q <= config_checksum;
        end
    end

    // Reset sequencer: registers held at defaults, status word still taking events, then done flag set
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_q   <= 8'h00;
            rst_busy_q  <= 1'b0;
            wake_prev_q <= 1'b0;
        end else begin
            wake_prev_q <= wake_lvl;
            if (start_rst) begin
                rst_cnt_q  <= `MESF_RST_CYCLES;
                rst_busy_q <= 1'b1;
            end else if (rst_busy_q) begin
                rst_cnt_q  <= rst_cnt_q - 8'h01;
                rst_busy_q <= rst_cnt_q != 8'h01;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h00000000;
            irq_n_q <= 1'b1;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h00000000;
            irq_n_q <= rst_busy_q ? 1'b1 : !irq_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign interrupt_out_one_n = irq_n_q;
    assign core_reset_pulse    = rst_busy_q;
endmodule

// [mesf_status_assertions.sv]
// Port-level timing checks for the event status block.
// Assumes it is bound onto mesf_status and sees only its ports.
`timescale 1ns/1ps
`include "mesf_params.svh"
module mesf_status_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        arst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Event pulses
    input wire logic [2:0]  total_noload_phases,
    input wire logic [2:0]  fundamental_noload_phases,
    input wire logic [2:0]  apparent_noload_phases,
    input wire logic [5:0]  crossing_timeout,
    input wire logic [5:0]  crossing_seen,
    input wire logic [2:0]  dip_phase_bits,
    input wire logic [2:0]  overcurrent_phase_bits,
    input wire logic [2:0]  overvoltage_phase_bits,
    input wire logic        current_peak_done,
    input wire logic        voltage_peak_done,
    // Outputs
    input wire logic        interrupt_out_one_n,
    input wire logic        core_reset_pulse
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // An event, then a status read shortly after, must show the flag
    sequence s_rd_stat;
        reg_rd && reg_addr == `MESF_ADDR_STATUS;
    endsequence
    property p_set(ev, int b);
        ev && !core_reset_pulse ##[1:2] s_rd_stat |=> reg_rdata[b];
    endproperty

    a_fixed_bits: assert property ($past(reg_rd) &&
        $past(reg_addr) == `MESF_ADDR_STATUS |-> reg_rdata[21] &&
        !reg_rdata[22] && reg_rdata[31:26] == 6'h00)
        else $error("fixed status bits wrong");
    a_total_noload: assert property (p_set(|total_noload_phases, 0))
        else $error("bit 0 not set");
    a_fund_noload: assert property (p_set(|fundamental_noload_phases, 1))
        else $error("bit 1 not set");
    a_app_noload: assert property (p_set(|apparent_noload_phases, 2))
        else $error("bit 2 not set");
    a_timeout_flag: assert property (p_set(crossing_timeout[0], 3))
        else $error("bit 3 not set");
    a_crossing_flag: assert property (p_set(crossing_seen[0], 9))
        else $error("bit 9 not set");
    a_sag_flag: assert property (p_set(|dip_phase_bits, 16))
        else $error("bit 16 not set");
    a_over_current: assert property (p_set(|overcurrent_phase_bits, 17))
        else $error("bit 17 not set");
    a_over_voltage: assert property (p_set(|overvoltage_phase_bits, 18))
        else $error("bit 18 not set");
    a_current_peak_register_flag: assert property (p_set(current_peak_done, 23))
        else $error("bit 23 not set");
    a_voltage_peak_register_flag: assert property (p_set(voltage_peak_done, 24))
        else $error("bit 24 not set");
    a_soft_start: assert property (reg_wr && reg_wdata[7] &&
        reg_addr == `MESF_ADDR_CONFIG && !core_reset_pulse
        |-> ##[1:2] core_reset_pulse) else $error("soft reset not started");
    a_reset_len: assert property ($rose(core_reset_pulse) |->
        ##15 core_reset_pulse ##1 !core_reset_pulse)
        else $error("reset sequence length wrong");
    a_quiet_irq: assert property (core_reset_pulse &&
        $past(core_reset_pulse, 2) |-> interrupt_out_one_n)
        else $error("interrupt low during reset sequence");
    a_done_irq: assert property ($fell(core_reset_pulse) |->
        ##[0:3] !interrupt_out_one_n) else $error("no interrupt at done");
endmodule

bind mesf_status mesf_status_chk u_chk (.ref_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .total_noload_phases,
    .fundamental_noload_phases, .apparent_noload_phases, .crossing_timeout,
    .crossing_seen, .dip_phase_bits, .overcurrent_phase_bits,
    .overvoltage_phase_bits, .current_peak_done, .voltage_peak_done,
    .interrupt_out_one_n, .core_reset_pulse);

// [mesf_host_model.sv]
// Host processor model driving the register port of the status block.
// Assumes one clock; read data stand only in the cycle after the strobe.
`timescale 1ns/1ps
`include "mesf_params.svh"
module mesf_host (
    // Clock
    input  wire logic        ref_clk,
    // Register port
    output logic      [15:0] reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // Bus idle from time zero
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Data is taken in the one cycle where it stands
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Flags are cleared by writing ones
    task automatic clear(input logic [31:0] bits);
        wr(`MESF_ADDR_STATUS, bits);
    endtask

    // Software reset request
    task automatic soft_reset();
        wr(`MESF_ADDR_CONFIG, 32'h00000080);
    endtask
endmodule

// [test_metering_event_status_flags.sv]
// Self-checking bench for the event status block with a host model.
// Assumes mesf_status, mesf_host and the checker bind are compiled.
`timescale 1ns/1ps
`include "mesf_params.svh"
module test_metering_event_status_flags;
    logic        ref_clk, arst_n, reg_wr, reg_rd;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, config_checksum;
    logic [2:0]  total_noload_phases, fundamental_noload_phases;
    logic [2:0]  apparent_noload_phases, voltage_rise, dip_phase_bits;
    logic [2:0]  overcurrent_phase_bits, overvoltage_phase_bits;
    logic [5:0]  crossing_timeout, crossing_seen;
    logic [23:0] summed_phase_current, neutral_current_sample;
    logic        current_peak_done, voltage_peak_done, power_mode_wake;
    logic        interrupt_out_one_n, core_reset_pulse;
    int          mismatches, tests_run;
    localparam logic [31:0] FIX = `MESF_FIXED_ONES;
    localparam logic [31:0] ALL = 32'hffffffff;

    mesf_status #(.LVL_W(24)) dut (.ref_clk, .arst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .total_noload_phases,
        .fundamental_noload_phases, .apparent_noload_phases,
        .crossing_timeout, .crossing_seen, .voltage_rise, .dip_phase_bits,
        .overcurrent_phase_bits, .overvoltage_phase_bits,
        .summed_phase_current, .neutral_current_sample, .current_peak_done,
        .voltage_peak_done, .config_checksum, .power_mode_wake,
        .interrupt_out_one_n, .core_reset_pulse);
    mesf_host host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata);

    // Clock at 8 ns
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task rds(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask
    // Drive all event pulses low
    task zero_ev();
        {total_noload_phases, fundamental_noload_phases, voltage_rise,
         apparent_noload_phases, dip_phase_bits, overcurrent_phase_bits,
         overvoltage_phase_bits, crossing_timeout, crossing_seen,
         current_peak_done, voltage_peak_done} <= '0;
    endtask
    // One-cycle pulse on the source of status bit i
    task pulse(input int i);
        @(posedge ref_clk);
        case (i)
            0: total_noload_phases <= 3'h1;
            1: fundamental_noload_phases <= 3'h1;
            2: apparent_noload_phases <= 3'h1;
            16: dip_phase_bits <= 3'h1;
            17: overcurrent_phase_bits <= 3'h1;
            18: overvoltage_phase_bits <= 3'h1;
            23: current_peak_done <= 1'b1;
            24: voltage_peak_done <= 1'b1;
            default: if (i < 9) crossing_timeout <= 6'h01 << (i - 3);
                     else crossing_seen <= 6'h01 << (i - 9);
        endcase
        @(posedge ref_clk);
        zero_ev();
    endtask

    task t_reset();
        tick(2);
        chk(interrupt_out_one_n, 1'b0);
        rds(`MESF_ADDR_STATUS, `MESF_STATUS_RST);
        rds(16'h1234, 32'h0);
        host.clear(ALL);
        tick(2);
        chk(interrupt_out_one_n, 1'b1);
        rds(`MESF_ADDR_STATUS, FIX);
        $display("test reset finished");
    endtask
    task t_events();
        for (int i = 0; i < 25; i++) begin
            if (i != 15 && (i < 19 || i > 22)) begin
                pulse(i);
                rds(`MESF_ADDR_STATUS, FIX | (32'h1 << i));
                host.clear(ALL);
            end
        end
        rds(`MESF_ADDR_NOLOAD, 32'h00000049);
        rds(`MESF_ADDR_PHSTAT, 32'h00001208);
        $display("test events finished");
    endtask
    // Besides reset-complete, only an enabled flag may hold the interrupt low
    task t_mask();
        host.wr(`MESF_ADDR_MASK, 32'h1);
        pulse(0);
        tick(3);
        chk(interrupt_out_one_n, 1'b0);
        host.clear(32'h1);
        tick(2);
        chk(interrupt_out_one_n, 1'b1);
        host.wr(`MESF_ADDR_MASK, 32'h0);
        pulse(0);
        tick(3);
        chk(interrupt_out_one_n, 1'b1);
        host.clear(ALL);
        $display("test mask finished");
    endtask
    task rises(input logic [8:0] s, input logic [31:0] e);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            voltage_rise <= s[3*k +: 3];
        end
        @(posedge ref_clk);
        voltage_rise <= 3'h0;
        tick(2);
        rds(`MESF_ADDR_STATUS, e);
        host.clear(ALL);
    endtask
    task t_seq();
        rises(9'b000_100_001, FIX | 32'h00080000);
        rises(9'b100_010_001, FIX);
        $display("test order finished");
    endtask
    // Sum of -1000 against neutral 100 gives a gap of 900
    task neutral(input logic [31:0] lvl, input logic [31:0] e);
        host.wr(`MESF_ADDR_LEVEL, lvl);
        @(posedge ref_clk);
        summed_phase_current   <= 24'hfffc18;
        neutral_current_sample <= 24'h000064;
        tick(2);
        @(posedge ref_clk);
        summed_phase_current   <= 24'h0;
        neutral_current_sample <= 24'h0;
        rds(`MESF_ADDR_STATUS, e);
        host.clear(ALL);
    endtask
    task t_mism();
        neutral(32'h000001f4, FIX | 32'h00100000);
        neutral(32'h000003e8, FIX);
        $display("test neutral finished");
    endtask
    task t_crc();
        host.wr(`MESF_ADDR_CONFIG, 32'h1);
        rds(`MESF_ADDR_CONFIG, 32'h1);
        @(posedge ref_clk);
        config_checksum <= 32'h0000005a;
        tick(2);
        rds(`MESF_ADDR_STATUS, FIX | 32'h02000000);
        host.wr(`MESF_ADDR_CONFIG, 32'h0);
        config_checksum <= 32'h0;
        host.clear(ALL);
        $display("test checksum finished");
    endtask
    // Command and wake both restart the core; the flag proves defaults
    task t_soft();
        for (int s = 0; s < 2; s++) begin
            pulse(0);
            if (s == 0)
                host.soft_reset();
            else begin
                @(posedge ref_clk);
                power_mode_wake <= 1'b1;
            end
            for (int k = 0; k < 20 && !core_reset_pulse; k++) tick(1);
            chk(core_reset_pulse, 1'b1);
            for (int k = 0; k < 40 && core_reset_pulse; k++) tick(1);
            @(posedge ref_clk);
            power_mode_wake <= 1'b0;
            tick(3);
            chk(interrupt_out_one_n, 1'b0);
            rds(`MESF_ADDR_STATUS, `MESF_STATUS_RST);
            host.clear(ALL);
        end
        $display("test soft reset finished");
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        config_checksum = 32'h0;
        summed_phase_current = 24'h0;
        neutral_current_sample = 24'h0;
        power_mode_wake = 1'b0;
        mismatches = 0;
        tests_run = 0;
        zero_ev();
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_events();
        t_mask();
        t_seq();
        t_mism();
        t_crc();
        t_soft();
        report_and_stop();
    end
endmodule
